// ===== rtl/fifo_buffer_pkg.sv
// Functional notes
// - One 512 by 8 buffer, shared both directions.
// - Depth select one limits usable depth to 255.
// - Small mode: one byte params; large: two. Threshold ninth bit still applies in small mode.
// - Running command reads or writes the buffer.
// - Clear bit resets pointers and fill count.
// - Writes increment, reads decrement the fill count.
// - Fill count readable; ninth bit in control register.
// - Threshold is reg 0x02 bit 2 plus 0x03.
// - One threshold serves near-full and near-empty.
// - Near-full when depth minus count within threshold.
// - Near-empty when count within threshold.
// - Write to full sets overflow and error flag.
// - Near-empty rising with enable raises interrupt.
// - Near-full rising with enable raises interrupt.
package fifo_buffer_pkg;
  localparam int DEPTH = 512;
  localparam int AW = 9;
  localparam int CW = 10;
  localparam logic [CW-1:0] DEPTH_FULL = 10'h200;
  localparam logic [CW-1:0] DEPTH_SMALL = 10'h0FF;
  localparam logic [5:0] ADDR_CTRL = 6'h02;
  localparam logic [5:0] ADDR_LEVEL = 6'h03;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  localparam logic [5:0] ADDR_COUNT = 6'h05;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h06;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h07;
  localparam int CTRL_CLEAR = 7;
  localparam int CTRL_SIZE = 6;
  localparam int CTRL_FULLF = 5;
  localparam int CTRL_EMPTYF = 4;
  localparam int CTRL_CNT8 = 3;
  localparam int CTRL_THR8 = 2;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_NEMPTY = 1;
  localparam int IRQ_NFULL = 2;
  localparam int NIRQ = 3;
  localparam logic [7:0] ZERO8 = 8'h00;

  typedef struct packed {
    logic valid;
    logic we;
    logic [7:0] data;
  } byte_req_t;

  typedef struct packed {
    logic near_full;
    logic near_empty;
    logic empty;
    logic full;
  } fill_flags_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;
endpackage

// ===== rtl/fifo_store.sv
`timescale 1ns/1ns
module fifo_store
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [fifo_buffer_pkg::CW-1:0] depth,
  input wire fifo_buffer_pkg::byte_req_t req,
  // Status
  output logic [7:0] rd_data,
  output logic [fifo_buffer_pkg::CW-1:0] count,
  output logic full,
  output logic empty,
  output logic overflow
);
  import fifo_buffer_pkg::*;

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [7:0] rd_q;
  wire do_wr = req.valid && req.we && !full;
  wire do_rd = req.valid && !req.we && !empty;

  assign full = count_q >= depth;
  assign empty = count_q == '0;
  assign overflow = req.valid && req.we && full;
  assign count = count_q;
  assign rd_data = rd_q;

  always_ff @(posedge clock)
  begin
    if (do_wr)
    begin
      mem[wr_ptr_q] <= req.data;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      rd_q <= ZERO8;
    end
    else if (clear)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        rd_q <= mem[rd_ptr_q];
      end
      count_q <= count_q + CW'(do_wr) - CW'(do_rd);
    end
  end
endmodule

// ===== rtl/fifo_alert.sv
`timescale 1ns/1ns
module fifo_alert
(
  // Inputs
  input wire logic [fifo_buffer_pkg::CW-1:0] depth,
  input wire logic [fifo_buffer_pkg::CW-1:0] count,
  input wire logic [fifo_buffer_pkg::AW-1:0] threshold,
  // Flags
  output fifo_buffer_pkg::fill_flags_t flags
);
  import fifo_buffer_pkg::*;

  wire [CW-1:0] thr = {1'b0, threshold};
  wire [CW-1:0] free = depth - count;

  assign flags.near_full = free <= thr;
  assign flags.near_empty = count <= thr;
  assign flags.empty = count == '0;
  assign flags.full = count >= depth;
endmodule

// ===== rtl/fifo_buffer_watermark.sv
`timescale 1ns/1ns
module fifo_buffer_watermark
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Internal protocol engine port
  input wire logic cmd_busy,
  input wire fifo_buffer_pkg::byte_req_t eng_req,
  output logic [7:0] eng_rd_data,
  // Interrupt
  output logic irq
);
  import fifo_buffer_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  bus_state_t state_q;
  logic [31:0] dat_q;
  logic ack_q;
  logic irq_q;
  logic size_q;
  logic [AW-1:0] thr_q;
  logic [NIRQ-1:0] stat_q;
  logic [NIRQ-1:0] en_q;
  fill_flags_t flags;
  fill_flags_t flags_prev_q;
  logic [CW-1:0] count;
  logic [7:0] rd_data;
  logic overflow;

  wire req_new = wb_cyc_i && wb_stb_i && state_q == BUS_IDLE;
  wire wr_en = req_new && wb_we_i && wb_sel_i[0];
  wire rd_en = req_new && !wb_we_i;
  wire hit_ctrl = wb_adr_i == ADDR_CTRL;
  wire hit_level = wb_adr_i == ADDR_LEVEL;
  wire hit_data = wb_adr_i == ADDR_DATA;
  wire hit_count = wb_adr_i == ADDR_COUNT;
  wire hit_stat = wb_adr_i == ADDR_IRQ_STAT;
  wire hit_en = wb_adr_i == ADDR_IRQ_EN;
  wire clear = wr_en && hit_ctrl && wb_dat_i[CTRL_CLEAR];

  // Command traffic owns the buffer while it runs; host data port requests are ignored then.
  wire host_data = req_new && hit_data && !cmd_busy && (wb_we_i ? wb_sel_i[0] : 1'b1);
  byte_req_t host_req;
  byte_req_t fifo_req;
  assign host_req.valid = host_data;
  assign host_req.we = wb_we_i;
  assign host_req.data = wb_dat_i[7:0];
  assign fifo_req = cmd_busy ? eng_req : host_req;

  wire [CW-1:0] depth = size_q ? DEPTH_SMALL : DEPTH_FULL;

  // ----------------------------------------
  // Storage and alerts
  // ----------------------------------------
  fifo_store u_store
  (
    .clock(clock),
    .rst_n(rst_n),
    .clear(clear),
    .depth(depth),
    .req(fifo_req),
    .rd_data(rd_data),
    .count(count),
    .full(),
    .empty(),
    .overflow(overflow)
  );

  fifo_alert u_alert
  (
    .depth(depth),
    .count(count),
    .threshold(thr_q),
    .flags(flags)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [7:0] ctrl_rd = {1'b0, size_q, flags.near_full, flags.near_empty,
                        count[8], thr_q[8], 2'b00};
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (hit_ctrl)
    begin
      rd_mux[7:0] = ctrl_rd;
    end
    else if (hit_level)
    begin
      rd_mux[7:0] = thr_q[7:0];
    end
    else if (hit_data)
    begin
      rd_mux[7:0] = rd_data;
    end
    else if (hit_count)
    begin
      rd_mux[7:0] = size_q ? count[7:0] : count[7:0];
    end
    else if (hit_stat)
    begin
      rd_mux[NIRQ-1:0] = stat_q;
    end
    else if (hit_en)
    begin
      rd_mux[NIRQ-1:0] = en_q;
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  // Only a rising alert latches, so a level that stays high raises one event.
  wire near_full_rise = flags.near_full && !flags_prev_q.near_full;
  wire near_empty_rise = flags.near_empty && !flags_prev_q.near_empty;
  wire [NIRQ-1:0] set_ev = {near_full_rise, near_empty_rise, overflow};

  wire wr_ctrl = wr_en && hit_ctrl;
  wire wr_level = wr_en && hit_level;
  wire wr_stat = wr_en && hit_stat;
  wire wr_irq_en = wr_en && hit_en;
  wire [NIRQ-1:0] clr_ev = wr_stat ? wb_dat_i[NIRQ-1:0] : '0;
  wire [NIRQ-1:0] irq_src = stat_q & en_q;
  wire irq_d = |irq_src;
  wire bus_take = req_new;
  bus_state_t state_d;
  assign state_d = bus_take ? BUS_ACK : BUS_IDLE;

  // ----------------------------------------
  // Status and enable bits
  // ----------------------------------------
  // Set wins over a write-one clear in the same cycle, so no event is ever lost.
  genvar g;
  generate
    for (g = 0; g < NIRQ; g++)
    begin : g_irq
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stat_q[g] <= 1'b0;
        end
        else if (set_ev[g])
        begin
          stat_q[g] <= 1'b1;
        end
        else if (clr_ev[g])
        begin
          stat_q[g] <= 1'b0;
        end
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          en_q[g] <= 1'b0;
        end
        else
        begin
          if (wr_irq_en)
          begin
            en_q[g] <= wb_dat_i[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // The state holds off a second take while ack stands, so one request gets one answer.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= BUS_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus_take;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dat_q <= '0;
    end
    else if (rd_en)
    begin
      dat_q <= rd_mux;
    end
    else
    begin
      dat_q <= '0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      size_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        size_q <= wb_dat_i[CTRL_SIZE];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thr_q[8] <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        thr_q[8] <= wb_dat_i[CTRL_THR8];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      thr_q[7:0] <= ZERO8;
    end
    else
    begin
      if (wr_level)
      begin
        thr_q[7:0] <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------
  // Alert history and interrupt pin
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_prev_q <= '0;
    end
    else
    begin
      flags_prev_q <= flags;
    end
  end

  // Registered so the pin never glitches on decode; it lags the status by one cycle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data for the data port is the byte popped at the ack edge, so it shows next access.
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq = irq_q;
  assign eng_rd_data = rd_data;
endmodule

// ===== sim/fifo_buffer_watermark_assertions.sv
`timescale 1ns/1ns
module fifo_buffer_watermark_assertions
(
  // Bus
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Interrupt
  input wire logic irq
);
  import fifo_buffer_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_ack_latency:
    assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o) else $error("ack late");
  chk_ack_cause:
    assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without request");
  chk_clear_reads:
    assert property (s_rd(ADDR_CTRL) |-> !wb_dat_o[CTRL_CLEAR]) else $error("clear read 1");
  chk_unmapped_zero:
    assert property (s_rd(6'h3F) |-> wb_dat_o == 32'h0) else $error("unmapped data");
  chk_stat_upper:
    assert property (s_rd(ADDR_IRQ_STAT) |-> wb_dat_o[7:3] == 5'h0) else $error("status");
  chk_irq_masked:
    assert property (wb_ack_o && wb_we_i && wb_adr_i == ADDR_IRQ_EN && wb_dat_i[2:0] == 3'h0
      |-> ##[1:3] !irq) else $error("masked irq");
  chk_reset_quiet:
    assert property ($rose(rst_n) |-> !wb_ack_o && !irq) else $error("busy after reset");
endmodule
bind fifo_buffer_watermark fifo_buffer_watermark_assertions u_chk (.clock(clock),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq(irq));

// ===== sim/engine_model.sv
`timescale 1ns/1ns
module engine_model
(
  // Clock and start
  input wire logic clock,
  input wire logic go,
  // Engine side
  output logic cmd_busy,
  output fifo_buffer_pkg::byte_req_t eng_req
);
  import fifo_buffer_pkg::*;
  int n;
  initial
  begin
    cmd_busy = 1'h0;
    eng_req = '0;
    forever
    begin
      @(posedge clock);
      if (go)
      begin
        cmd_busy <= 1'h1;
        for (n = 0; n < 4; n++)
        begin
          eng_req <= '{1'h1, 1'h1, 8'hA0 + n[7:0]};
          @(posedge clock);
        end
        eng_req <= '0;
        cmd_busy <= 1'h0;
      end
    end
  end
endmodule

// ===== sim/fifo_buffer_watermark_tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", n, e, a); end end
module fifo_buffer_watermark_tb_top;
  import fifo_buffer_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic cmd_busy;
  byte_req_t eng_req;
  logic [7:0] eng_rd_data;
  logic irq;
  logic go = 1'h0;
  logic [7:0] r;
  int err_count = 0;
  int checks = 0;
  int i;
  fifo_buffer_watermark u_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_busy(cmd_busy),
    .eng_req(eng_req), .eng_rd_data(eng_rd_data), .irq(irq));
  engine_model u_eng (.clock(clock), .go(go), .cmd_busy(cmd_busy), .eng_req(eng_req));
  initial
  begin
    forever #50 clock = ~clock;
  end
  // ----------------------------------------
  // Bus access and closing
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do
      @(posedge clock);
    while (wb_ack_o !== 1'h1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clock);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A loop of 256 data writes dominates the run, so the limit leaves ample margin over it.
  initial
  begin
    repeat (5000) @(posedge clock);
    err_count++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    xfer(1'h1, ADDR_IRQ_STAT, 8'h07, r);
    xfer(1'h0, ADDR_CTRL, 8'h00, r);
    `CHK("ctrl_idle", 8'h10, r)
    xfer(1'h1, ADDR_LEVEL, 8'h02, r);
    xfer(1'h1, ADDR_IRQ_EN, 8'h05, r);
    xfer(1'h1, ADDR_CTRL, 8'h40, r);
    for (i = 0; i < 256; i++)
      xfer(1'h1, ADDR_DATA, i[7:0], r);
    xfer(1'h0, ADDR_COUNT, 8'h00, r);
    `CHK("count_small", 8'hFF, r)
    xfer(1'h0, ADDR_IRQ_STAT, 8'h00, r);
    `CHK("status", 8'h05, r)
    `CHK("irq_on", 1'h1, irq)
    xfer(1'h1, ADDR_IRQ_EN, 8'h00, r);
    @(posedge clock);
    `CHK("irq_masked", 1'h0, irq)
    xfer(1'h1, ADDR_IRQ_EN, 8'h05, r);
    xfer(1'h1, ADDR_IRQ_STAT, 8'h05, r);
    @(posedge clock);
    `CHK("irq_cleared", 1'h0, irq)
    xfer(1'h1, ADDR_CTRL, 8'h80, r);
    xfer(1'h0, ADDR_IRQ_STAT, 8'h00, r);
    `CHK("stat_nempty", 8'h02, r)
    xfer(1'h1, ADDR_IRQ_EN, 8'h07, r);
    @(posedge clock);
    `CHK("irq_nempty", 1'h1, irq)
    xfer(1'h0, ADDR_DATA, 8'h00, r);
    xfer(1'h0, ADDR_COUNT, 8'h00, r);
    `CHK("count_clear", 8'h00, r)
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
    while (cmd_busy) @(posedge clock);
    xfer(1'h0, ADDR_DATA, 8'h00, r);
    `CHK("popped", 8'hA0, eng_rd_data)
    xfer(1'h0, ADDR_COUNT, 8'h00, r);
    `CHK("count_pop", 8'h03, r)
    xfer(1'h1, ADDR_CTRL, 8'h04, r);
    xfer(1'h0, ADDR_CTRL, 8'h00, r);
    `CHK("ctrl_high", 8'h14, r)
    xfer(1'h0, 6'h3F, 8'h00, r);
    `CHK("unmapped", 8'h00, r)
    finish_test();
  end
endmodule
